// file: hw/sfrc_pkg.sv
// Behaviour
// - first read byte leaves MSB first, falling edge
// - address advances per byte until deselect
// - reads ignored while busy flag set
// - 0Bh adds eight dummy clocks before data
// - four-wire mode dummy count from parameter bits
// - four-wire dummy count back to four on reset
// - 3Bh: eight dummies, data on IO0 and IO1
// - 6Bh accepted only with quad enable set
// - 6Bh: eight dummies, data on four lines
// - dual mode Ax skips next opcode
// - other mode value or reset needs opcode again
// - mode low nibble ignored, lines released first
// - EBh needs quad enable, four-line address
// - quad mode Ax skips next EBh opcode
// - wrap setting applies to next quad read
// - wrap confines output to aligned section
// - four-wire quad read uses configured dummies
// - four-wire mode byte counts within dummies
// - no wrap on four-wire EBh, use 0Ch
// - every field shifted MSB first
// - quad data high nibble first, IO3 top
package sfrc_pkg;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_BURST_WRAP = 8'h0c;
	localparam logic [3:0] CONT_KEY = 4'ha;
	localparam int ADDR_BITS = 24;
	localparam int DATA_BITS = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [4:0] ADDR_CLOCKS = 5'h18;
	localparam logic [4:0] BYTE_CLOCKS = 5'h08;
	localparam logic [4:0] CMD_CLOCKS_QPI = 5'h02;
	localparam logic [3:0] DUMMY_DEFAULT = 4'h4;
	localparam logic [3:0] DUMMY_MID = 4'h6;
	localparam logic [3:0] DUMMY_FAST = 4'h8;
	localparam logic [3:0] DUMMY_QUAD_SPI = 4'h4;
	localparam logic [3:0] MODE_QPI_CLOCKS = 4'h2;
	localparam logic [2:0] LANE1 = 3'h1;
	localparam logic [2:0] LANE2 = 3'h2;
	localparam logic [2:0] LANE4 = 3'h4;
	localparam logic [7:0] EMPTY_BYTE = 8'hff;
	localparam logic [7:0] WRAP_UNIT = 8'h08;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD = 3'h1,
		ST_ADDR = 3'h3,
		ST_MODE = 3'h2,
		ST_DUMMY = 3'h6,
		ST_DATA = 3'h7,
		ST_IGNORE = 3'h5
	} sfrc_state_t;

	typedef struct packed {
		logic ok;
		logic needQuad;
		logic [2:0] addrW;
		logic modeOn;
		logic [3:0] dummy;
		logic [2:0] dataW;
		logic wrap;
		logic dualCont;
		logic quadCont;
	} sfrc_plan_t;

	typedef struct packed {
		logic busy;
		logic quadEnable;
		logic fourWireMode;
		logic wrapEnable;
		logic [1:0] wrapLength;
	} sfrc_cfg_t;
endpackage

// file: hw/sfrc_top.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================
// read data buffer between array fetch and shifter
module sfrc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wrPtr;
	logic [PW:0] rdPtr;

	// extra pointer bit tells full from empty
	assign inReady = (wrPtr[PW] == rdPtr[PW]) || (wrPtr[PW-1:0] != rdPtr[PW-1:0]);
	assign outValid = wrPtr != rdPtr;
	assign outData = mem[rdPtr[PW-1:0]];

	// pointers; flush drops stale bytes of an ended frame
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else if (flush)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else
		begin
			if (inValid && inReady)
				wrPtr <= wrPtr + 1'b1;
			if (outValid && outReady)
				rdPtr <= rdPtr + 1'b1;
		end

	// storage, no reset needed
	always_ff @(posedge clk)
		if (inValid && inReady)
			mem[wrPtr[PW-1:0]] <= inData;
endmodule

// =====================================================
// read command front end
module sfrc_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic csN,
	input wire logic sck,
	input wire logic [3:0] ioIn,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe,
	input wire sfrc_pkg::sfrc_cfg_t cfg,
	input wire logic paramWrite,
	input wire logic [1:0] paramBits,
	input wire logic resetCmd,
	input wire logic modeBitReset,
	output logic memReq,
	output logic [23:0] memAddr,
	input wire logic [7:0] memData,
	input wire logic memValid,
	output logic continuousActive
);
	logic [1:0] sckS;
	logic [1:0] csS;
	logic [3:0] ioS0;
	logic [3:0] ioS1;
	logic sckPrev;
	logic csPrev;
	logic sckRise;
	logic sckFall;
	logic csHigh;
	logic csFall;
	sfrc_pkg::sfrc_state_t state;
	sfrc_pkg::sfrc_plan_t plan;
	sfrc_pkg::sfrc_plan_t decoded;
	logic [4:0] phaseLeft;
	logic [23:0] shiftReg;
	logic [23:0] sIn;
	logic [2:0] curW;
	logic lastEdge;
	logic cmdDone;
	logic addrDone;
	logic modeDone;
	logic contDual;
	logic contQuad;
	logic [3:0] dummyClocks;
	logic [2:0] outLeft;
	logic [7:0] outShift;
	logic [7:0] curByte;
	logic loadByte;
	logic fetching;
	logic reqBusy;
	logic [23:0] fetchAddr;
	logic wrapOn;
	logic [7:0] wrapMaskR;
	logic fifoInReady;
	logic fifoOutValid;
	logic [7:0] fifoOutData;

	// =================================================
	// helpers
	function automatic logic [23:0] shiftIn(input logic [23:0] old, input logic [3:0] io,
		input logic [2:0] w);
		unique case (w)
			sfrc_pkg::LANE2: shiftIn = {old[21:0], io[1:0]};
			sfrc_pkg::LANE4: shiftIn = {old[19:0], io[3:0]};
			default: shiftIn = {old[22:0], io[0]};
		endcase
	endfunction

	function automatic logic [4:0] phaseClocks(input logic [4:0] bits, input logic [2:0] w);
		unique case (w)
			sfrc_pkg::LANE2: phaseClocks = bits >> 1;
			sfrc_pkg::LANE4: phaseClocks = bits >> 2;
			default: phaseClocks = bits;
		endcase
	endfunction

	function automatic logic [7:0] shiftOut(input logic [7:0] b, input logic [2:0] w);
		unique case (w)
			sfrc_pkg::LANE2: shiftOut = b << 2;
			sfrc_pkg::LANE4: shiftOut = b << 4;
			default: shiftOut = b << 1;
		endcase
	endfunction

	// lane map: single on IO1, dual IO1/IO0, quad IO3..IO0
	function automatic logic [3:0] laneOut(input logic [7:0] b, input logic [2:0] w);
		unique case (w)
			sfrc_pkg::LANE2: laneOut = {2'b00, b[7:6]};
			sfrc_pkg::LANE4: laneOut = b[7:4];
			default: laneOut = {2'b00, b[7], 1'b0};
		endcase
	endfunction

	function automatic logic [3:0] laneMask(input logic [2:0] w);
		unique case (w)
			sfrc_pkg::LANE2: laneMask = 4'h3;
			sfrc_pkg::LANE4: laneMask = 4'hf;
			default: laneMask = 4'h2;
		endcase
	endfunction

	// per opcode: lane widths, mode byte, dummy clocks, wrap
	function automatic sfrc_pkg::sfrc_plan_t decodeOp(input logic [7:0] op, input logic four_wire_command_mode,
		input logic wrapEn, input logic [3:0] dcfg);
		sfrc_pkg::sfrc_plan_t p;
		p = '0;
		p.addrW = sfrc_pkg::LANE1;
		p.dataW = sfrc_pkg::LANE1;
		case (op)
			sfrc_pkg::OP_READ: p.ok = !four_wire_command_mode;
			sfrc_pkg::OP_FAST:
			begin
				p.ok = 1'b1;
				p.dummy = four_wire_command_mode ? dcfg : sfrc_pkg::DUMMY_FAST;
				p.addrW = four_wire_command_mode ? sfrc_pkg::LANE4 : sfrc_pkg::LANE1;
				p.dataW = p.addrW;
			end
			sfrc_pkg::OP_DUAL_OUT:
			begin
				p.ok = !four_wire_command_mode;
				p.dummy = sfrc_pkg::DUMMY_FAST;
				p.dataW = sfrc_pkg::LANE2;
			end
			sfrc_pkg::OP_QUAD_OUT:
			begin
				p.ok = !four_wire_command_mode;
				p.needQuad = 1'b1;
				p.dummy = sfrc_pkg::DUMMY_FAST;
				p.dataW = sfrc_pkg::LANE4;
			end
			sfrc_pkg::OP_DUAL_IO:
			begin
				p.ok = !four_wire_command_mode;
				p.addrW = sfrc_pkg::LANE2;
				p.modeOn = 1'b1;
				p.dataW = sfrc_pkg::LANE2;
				p.dualCont = 1'b1;
			end
			sfrc_pkg::OP_QUAD_IO:
			begin
				p.ok = 1'b1;
				p.needQuad = 1'b1;
				p.addrW = sfrc_pkg::LANE4;
				p.modeOn = 1'b1;
				// four-wire mode: mode clocks are part of the dummies
				p.dummy = four_wire_command_mode ? dcfg - sfrc_pkg::MODE_QPI_CLOCKS : sfrc_pkg::DUMMY_QUAD_SPI;
				p.dataW = sfrc_pkg::LANE4;
				p.wrap = wrapEn && !four_wire_command_mode;
				p.quadCont = 1'b1;
			end
			sfrc_pkg::OP_BURST_WRAP:
			begin
				p.ok = four_wire_command_mode;
				p.addrW = sfrc_pkg::LANE4;
				p.dummy = dcfg;
				p.dataW = sfrc_pkg::LANE4;
				p.wrap = 1'b1;
			end
			default: p.ok = 1'b0;
		endcase
		decodeOp = p;
	endfunction

	// next byte address, held in the aligned section when wrapping
	function automatic logic [23:0] stepAddr(input logic [23:0] a, input logic on,
		input logic [7:0] m);
		logic [7:0] low;
		low = a[7:0] + 8'h01;
		stepAddr = on ? {a[23:8], (a[7:0] & ~m) | (low & m)} : a + 24'h000001;
	endfunction

	// =================================================
	// pin synchronisers, edge detection
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			sckS <= 2'b00;
			csS <= 2'b11;
			ioS0 <= 4'h0;
			ioS1 <= 4'h0;
			sckPrev <= 1'b0;
			csPrev <= 1'b1;
		end
		else
		begin
			sckS <= {sckS[0], sck};
			csS <= {csS[0], csN};
			ioS0 <= ioIn;
			ioS1 <= ioS0;
			sckPrev <= sckS[1];
			csPrev <= csS[1];
		end

	assign sckRise = sckS[1] && !sckPrev;
	assign sckFall = !sckS[1] && sckPrev;
	assign csHigh = csS[1];
	assign csFall = !csS[1] && csPrev;

	// =================================================
	// input phases
	always_comb
	begin
		curW = sfrc_pkg::LANE1;
		if (state == sfrc_pkg::ST_CMD)
			curW = cfg.fourWireMode ? sfrc_pkg::LANE4 : sfrc_pkg::LANE1;
		else if (state == sfrc_pkg::ST_ADDR || state == sfrc_pkg::ST_MODE)
			curW = plan.addrW;
	end

	assign sIn = shiftIn(shiftReg, ioS1, curW);
	assign lastEdge = sckRise && !csHigh && !csFall && phaseLeft == 5'h01;
	assign cmdDone = lastEdge && state == sfrc_pkg::ST_CMD;
	assign addrDone = lastEdge && state == sfrc_pkg::ST_ADDR;
	assign modeDone = lastEdge && state == sfrc_pkg::ST_MODE;
	assign decoded = decodeOp(sIn[7:0], cfg.fourWireMode, cfg.wrapEnable, dummyClocks);

	// frame sequencer; opcode skipped when continuous mode is armed
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			state <= sfrc_pkg::ST_IDLE;
			plan <= '0;
			phaseLeft <= 5'h00;
			shiftReg <= 24'h000000;
		end
		else if (csHigh)
			state <= sfrc_pkg::ST_IDLE;
		else if (csFall)
		begin
			shiftReg <= 24'h000000;
			if ((contDual || contQuad) && !cfg.busy)
			begin
				plan <= decodeOp(contQuad ? sfrc_pkg::OP_QUAD_IO : sfrc_pkg::OP_DUAL_IO,
					cfg.fourWireMode, cfg.wrapEnable, dummyClocks);
				state <= sfrc_pkg::ST_ADDR;
				phaseLeft <= phaseClocks(sfrc_pkg::ADDR_CLOCKS,
					contQuad ? sfrc_pkg::LANE4 : sfrc_pkg::LANE2);
			end
			else
			begin
				state <= sfrc_pkg::ST_CMD;
				phaseLeft <= cfg.fourWireMode ? sfrc_pkg::CMD_CLOCKS_QPI : sfrc_pkg::BYTE_CLOCKS;
			end
		end
		else if (sckRise)
		begin
			unique case (state)
				sfrc_pkg::ST_IDLE, sfrc_pkg::ST_DATA, sfrc_pkg::ST_IGNORE: ;
				sfrc_pkg::ST_CMD:
				begin
					shiftReg <= sIn;
					phaseLeft <= phaseLeft - 5'h01;
					if (cmdDone)
					begin
						// busy or quad lines off: sit out the frame silently
						if (!decoded.ok || cfg.busy || (decoded.needQuad && !cfg.quadEnable))
							state <= sfrc_pkg::ST_IGNORE;
						else
						begin
							plan <= decoded;
							state <= sfrc_pkg::ST_ADDR;
							phaseLeft <= phaseClocks(sfrc_pkg::ADDR_CLOCKS, decoded.addrW);
						end
					end
				end
				sfrc_pkg::ST_ADDR, sfrc_pkg::ST_MODE, sfrc_pkg::ST_DUMMY:
				begin
					shiftReg <= sIn;
					phaseLeft <= phaseLeft - 5'h01;
					if (addrDone && plan.modeOn)
					begin
						state <= sfrc_pkg::ST_MODE;
						phaseLeft <= phaseClocks(sfrc_pkg::BYTE_CLOCKS, plan.addrW);
					end
					else if ((addrDone || modeDone) && plan.dummy != 4'h0)
					begin
						state <= sfrc_pkg::ST_DUMMY;
						phaseLeft <= {1'b0, plan.dummy};
					end
					else if (lastEdge)
						state <= sfrc_pkg::ST_DATA;
				end
				default: state <= sfrc_pkg::ST_IDLE;
			endcase
		end

	// =================================================
	// continuous read memory; set beats a same-cycle mode reset
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			contDual <= 1'b0;
			contQuad <= 1'b0;
			continuousActive <= 1'b0;
		end
		else
		begin
			continuousActive <= contDual || contQuad;
			if (modeBitReset || resetCmd)
			begin
				contDual <= 1'b0;
				contQuad <= 1'b0;
			end
			if (modeDone)
			begin
				// only the upper nibble counts
				contDual <= plan.dualCont && sIn[7:4] == sfrc_pkg::CONT_KEY;
				contQuad <= plan.quadCont && sIn[7:4] == sfrc_pkg::CONT_KEY;
			end
		end

	// =================================================
	// four-wire dummy count; 11 is read as eight
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			dummyClocks <= sfrc_pkg::DUMMY_DEFAULT;
		else if (resetCmd)
			dummyClocks <= sfrc_pkg::DUMMY_DEFAULT;
		else if (paramWrite)
		begin
			unique case (paramBits)
				2'b00: dummyClocks <= sfrc_pkg::DUMMY_DEFAULT;
				2'b01: dummyClocks <= sfrc_pkg::DUMMY_MID;
				default: dummyClocks <= sfrc_pkg::DUMMY_FAST;
			endcase
		end

	// =================================================
	// array fetch; first request already in the last address cycle
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			fetching <= 1'b0;
			reqBusy <= 1'b0;
			fetchAddr <= 24'h000000;
			memReq <= 1'b0;
			memAddr <= 24'h000000;
			wrapOn <= 1'b0;
			wrapMaskR <= 8'h00;
		end
		else
		begin
			memReq <= 1'b0;
			if (memValid)
				reqBusy <= 1'b0;
			if (csHigh)
				fetching <= 1'b0;
			else if (addrDone)
			begin
				fetching <= 1'b1;
				wrapOn <= plan.wrap;
				wrapMaskR <= (sfrc_pkg::WRAP_UNIT << cfg.wrapLength) - 8'h01;
				memReq <= 1'b1;
				reqBusy <= 1'b1;
				memAddr <= sIn;
				fetchAddr <= stepAddr(sIn, plan.wrap,
					(sfrc_pkg::WRAP_UNIT << cfg.wrapLength) - 8'h01);
			end
			// a full buffer stalls the fetch until the shifter drains it
			else if (fetching && !reqBusy && !memReq && fifoInReady)
			begin
				memReq <= 1'b1;
				reqBusy <= 1'b1;
				memAddr <= fetchAddr;
				fetchAddr <= stepAddr(fetchAddr, wrapOn, wrapMaskR);
			end
		end

	sfrc_fifo #(
		.WIDTH(sfrc_pkg::DATA_BITS),
		.DEPTH(sfrc_pkg::FIFO_DEPTH)
	) buffer (
		.clk(clk),
		.resetn(resetn),
		.flush(csHigh),
		.inValid(memValid && fetching),
		.inReady(fifoInReady),
		.inData(memData),
		.outValid(fifoOutValid),
		.outReady(loadByte),
		.outData(fifoOutData)
	);

	// =================================================
	// data shifter on falling edges; an underrun sends ones
	assign loadByte = sckFall && !csHigh && state == sfrc_pkg::ST_DATA && outLeft == 3'h0;
	assign curByte = (outLeft != 3'h0) ? shiftOut(outShift, plan.dataW) :
		(fifoOutValid ? fifoOutData : sfrc_pkg::EMPTY_BYTE);

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			outLeft <= 3'h0;
			outShift <= 8'h00;
			ioOut <= 4'h0;
			ioOe <= 4'h0;
		end
		else if (csHigh)
		begin
			outLeft <= 3'h0;
			ioOe <= 4'h0;
		end
		else if (sckFall && state == sfrc_pkg::ST_DATA)
		begin
			outShift <= curByte;
			ioOut <= laneOut(curByte, plan.dataW);
			// lines turn to output only at the first data falling edge
			ioOe <= laneMask(plan.dataW);
			outLeft <= loadByte ? 3'(phaseClocks(sfrc_pkg::BYTE_CLOCKS, plan.dataW) - 5'h01) :
				outLeft - 3'h1;
		end

	// =================================================
	// checks
	logic [23:0] lastReqAddr;
	logic [23:0] baseAddr;
	logic reqSeen;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			lastReqAddr <= 24'h000000;
			baseAddr <= 24'h000000;
			reqSeen <= 1'b0;
		end
		else
		begin
			if (memReq)
				lastReqAddr <= memAddr;
			if (addrDone)
				baseAddr <= sIn;
			if (addrDone || csHigh)
				reqSeen <= 1'b0;
			else if (memReq)
				reqSeen <= 1'b1;
		end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	deselect_quiet_a: assert property (csHigh |=> ioOe == 4'h0)
		else $error("lines driven after deselect");
	busy_refuse_a: assert property (cmdDone && cfg.busy |=> state == sfrc_pkg::ST_IGNORE)
		else $error("read taken while busy");
	quad_gate_a: assert property (cmdDone && decoded.needQuad && !cfg.quadEnable
		|=> state == sfrc_pkg::ST_IGNORE)
		else $error("quad read taken without quad enable");
	ignore_quiet_a: assert property (state == sfrc_pkg::ST_IGNORE |-> ioOe == 4'h0)
		else $error("lines driven in refused frame");
	dummy_default_a: assert property (resetCmd |=> dummyClocks == sfrc_pkg::DUMMY_DEFAULT)
		else $error("dummy count not back to default");
	dummy_mid_a: assert property (paramWrite && !resetCmd && paramBits == 2'b01
		|=> dummyClocks == sfrc_pkg::DUMMY_MID)
		else $error("dummy count not six");
	addr_step_a: assert property (memReq && reqSeen && !wrapOn
		|-> memAddr == lastReqAddr + 24'h000001)
		else $error("fetch address did not advance by one");
	wrap_section_a: assert property (memReq && wrapOn |-> memAddr[23:8] == baseAddr[23:8]
		&& (memAddr[7:0] & ~wrapMaskR) == (baseAddr[7:0] & ~wrapMaskR))
		else $error("wrapped fetch left its section");
	cont_set_a: assert property (modeDone && plan.dualCont && sIn[7:4] == sfrc_pkg::CONT_KEY
		|=> contDual ##1 continuousActive)
		else $error("continuous dual mode not armed");
	cont_clear_a: assert property (modeBitReset && !modeDone |=> !contDual && !contQuad)
		else $error("mode reset left continuous mode");
	msb_out_a: assert property (loadByte && fifoOutValid && plan.dataW == sfrc_pkg::LANE1
		|=> outShift == $past(fifoOutData) && ioOut[1] == outShift[7])
		else $error("single line byte not MSB first");
	nibble_out_a: assert property (loadByte && fifoOutValid && plan.dataW == sfrc_pkg::LANE4
		|=> ioOut == outShift[7:4] && ioOe == 4'hf)
		else $error("quad byte not high nibble first");

	dual_data_c: cover property (loadByte && plan.dataW == sfrc_pkg::LANE2);
	cont_entry_c: cover property (csFall && contQuad ##[1:40] state == sfrc_pkg::ST_ADDR);
	wrap_fetch_c: cover property (memReq && wrapOn && memAddr[7:0] == (baseAddr[7:0] & ~wrapMaskR));
endmodule

`default_nettype wire

// file: verification/sfrc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================
// host controller: select, clock and the command phases
module sfrc_host_model (
	input wire logic clk,
	output logic csN,
	output logic sck,
	output logic [3:0] linkIo,
	input wire logic [3:0] devOut,
	input wire logic [3:0] devOe
);
	logic [3:0] hostIo = 4'h0;

	// pin level: device wins where it drives, else the host value
	assign linkIo = (devOe & devOut) | (~devOe & hostIo);

	// clock idles low outside frames, select idles high
	initial
	begin
		csN = 1'b1;
		sck = 1'b0;
	end

	task automatic halfBit();
		repeat (4) @(posedge clk);
	endtask

	task automatic openFrame();
		csN <= 1'b0;
		halfBit();
	endtask

	// the gap covers the select synchroniser
	task automatic closeFrame();
		csN <= 1'b1;
		repeat (8) @(posedge clk);
	endtask

	// bits set while the clock is low, taken on the rise, msb first
	task automatic sendBits(input logic [31:0] v, input int lanes, input int clocks);
		int k;
		logic [3:0] mask;
		mask = 4'((32'h1 << lanes) - 1);
		for (k = clocks - 1; k >= 0; k--)
		begin
			hostIo <= (4'(v >> (k * lanes)) & mask) | (~hostIo & ~mask);
			halfBit();
			sck <= 1'b1;
			halfBit();
			sck <= 1'b0;
		end
	endtask

	// sampled late in the high phase, long after the device's fall update
	task automatic readBits(input int lanes, input int clocks, output logic [7:0] v,
		output logic [3:0] oe);
		int k;
		v = 8'h00;
		oe = 4'h0;
		for (k = 0; k < clocks; k++)
		begin
			hostIo <= ~hostIo; // released lines toggle so a stale level cannot pass
			halfBit();
			sck <= 1'b1;
			halfBit();
			v = (v << lanes) | 8'(lanes == 1 ? {3'h0, devOut[1]} : devOut & 4'((32'h1 << lanes) - 1));
			oe = devOe;
			sck <= 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin failures++; $display("Error %s expected %h seen %h", what, exp, got); end end

// =====================================================
// bench top: host model on the link, array answers a fixed pattern
module testbench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic csN;
	logic sck;
	logic [3:0] linkIo;
	logic [3:0] ioOut;
	logic [3:0] ioOe;
	sfrc_pkg::sfrc_cfg_t cfg = '{1'b0, 1'b1, 1'b0, 1'b0, 2'h0};
	logic paramWrite = 1'b0;
	logic [1:0] paramBits = 2'h0;
	logic resetCmd = 1'b0;
	logic modeBitReset = 1'b0;
	logic memReq;
	logic [23:0] memAddr;
	logic [7:0] memData = 8'h00;
	logic memValid = 1'b0;
	logic continuousActive;
	logic [23:0] a;
	int reqCount = 0;
	int dq;
	int failures = 0;
	int samplesChecked = 0;
	int seedSet;
	int t;
	localparam logic [7:0] OPS [6] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb};
	localparam int AL [6] = '{1, 1, 1, 1, 2, 4};
	localparam int ML [6] = '{0, 0, 0, 0, 2, 4};
	localparam int DM [6] = '{0, 8, 8, 8, 0, 4};
	localparam int DL [6] = '{1, 1, 2, 4, 2, 4};

	sfrc_top sfrc_top_i (.clk(clk), .resetn(resetn), .csN(csN), .sck(sck), .ioIn(linkIo),
		.ioOut(ioOut), .ioOe(ioOe), .cfg(cfg), .paramWrite(paramWrite), .paramBits(paramBits),
		.resetCmd(resetCmd), .modeBitReset(modeBitReset), .memReq(memReq), .memAddr(memAddr),
		.memData(memData), .memValid(memValid), .continuousActive(continuousActive));
	sfrc_host_model sfrc_host_model_i (.clk(clk), .csN(csN), .sck(sck), .linkIo(linkIo),
		.devOut(ioOut), .devOe(ioOe));

	initial
	begin
		forever #20 clk = ~clk;
	end

	// array answers exactly one cycle after each request
	always @(posedge clk)
	begin
		memValid <= memReq;
		memData <= pat(memAddr);
		if (memReq === 1'b1)
			reqCount <= reqCount + 1;
	end

	function automatic logic [7:0] pat(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3c;
	endfunction

	// next byte address; wl < 0 means a plain linear stream
	function automatic logic [23:0] step(input logic [23:0] x, input int wl);
		logic [23:0] m;
		if (wl < 0)
			return x + 24'h1;
		m = (24'h8 << wl) - 24'h1;
		return (x & ~m) | ((x + 24'h1) & m);
	endfunction

	function automatic logic [3:0] laneOe(input int dl, input bit ok);
		if (!ok)
			return 4'h0;
		return (dl == 1) ? 4'h2 : 4'((32'h1 << dl) - 1);
	endfunction

	task automatic note(input string s);
		$display("test %s finished", s);
	endtask

	// one frame: optional opcode, address, optional mode, dummies, n data bytes
	task automatic readFrame(input logic [7:0] op, input int opL, input logic [23:0] addr,
		input int aL, input logic [7:0] mode, input int mL, input int dum, input int dL,
		input int n, input bit ok, input int wl);
		logic [7:0] v;
		logic [3:0] oe;
		logic [23:0] x;
		int i;
		x = addr;
		sfrc_host_model_i.openFrame();
		if (opL > 0)
			sfrc_host_model_i.sendBits(32'(op), opL, 8 / opL);
		sfrc_host_model_i.sendBits(32'(addr), aL, 24 / aL);
		if (mL > 0)
			sfrc_host_model_i.sendBits(32'(mode), mL, 8 / mL);
		if (dum > 0)
			sfrc_host_model_i.readBits(1, dum, v, oe);
		for (i = 0; i < n; i++)
		begin
			sfrc_host_model_i.readBits(dL, 8 / dL, v, oe);
			`CHK("lane enables", laneOe(dL, ok), oe)
			if (ok)
				`CHK("read byte", pat(x), v)
			x = step(x, wl);
		end
		sfrc_host_model_i.closeFrame();
	endtask

	task automatic chkCont(input logic e);
		@(negedge clk);
		`CHK("continuous mode", e, continuousActive)
		@(posedge clk);
	endtask

	// long stream: fetch must stall with the buffer full, so requests = bytes + depth
	task automatic bufferTest();
		int r0;
		cfg.fourWireMode <= 1'b0;
		@(posedge clk);
		r0 = reqCount;
		readFrame(8'h03, 1, 24'($urandom), 1, 8'h00, 0, 0, 1, 12, 1'b1, -1);
		@(negedge clk);
		`CHK("buffer requests", 12 + sfrc_pkg::FIFO_DEPTH, reqCount - r0)
		`CHK("lanes released", 4'h0, ioOe)
		`CHK("request idle", 1'b0, memReq)
		@(posedge clk);
		note("buffer");
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under this span
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		give_verdict();
	end

	initial
	begin
		seedSet = $urandom(32'h2799);
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (10) @(posedge clk);
		// every single-wire-command read kind with a random start
		for (t = 0; t < 6; t++)
			readFrame(OPS[t], 1, 24'($urandom), AL[t], 8'h00, ML[t], DM[t], DL[t], 3, 1'b1, -1);
		note("spi reads");
		// busy refuses reads; quad opcodes need the quad enable bit
		cfg.busy <= 1'b1;
		readFrame(8'h03, 1, 24'($urandom), 1, 8'h00, 0, 0, 1, 2, 1'b0, -1);
		cfg.busy <= 1'b0;
		cfg.quadEnable <= 1'b0;
		for (t = 3; t < 6; t += 2)
			readFrame(OPS[t], 1, 24'($urandom), AL[t], 8'h00, ML[t], DM[t], DL[t], 2, 1'b0, -1);
		cfg.quadEnable <= 1'b1;
		note("refusals");
		// mode byte Ax arms opcode-less frames, other values or a reset disarm
		readFrame(8'hbb, 1, 24'($urandom), 2, 8'ha0 | 8'($urandom % 16), 2, 0, 2, 2, 1'b1, -1);
		chkCont(1'b1);
		readFrame(8'h00, 0, 24'($urandom), 2, 8'h35, 2, 0, 2, 2, 1'b1, -1);
		chkCont(1'b0);
		readFrame(8'heb, 1, 24'($urandom), 4, 8'ha7, 4, 4, 4, 2, 1'b1, -1);
		readFrame(8'h00, 0, 24'($urandom), 4, 8'had, 4, 4, 4, 2, 1'b1, -1);
		chkCont(1'b1);
		modeBitReset <= 1'b1;
		@(posedge clk);
		modeBitReset <= 1'b0;
		// the status output lags the cleared flag by one cycle
		@(posedge clk);
		chkCont(1'b0);
		readFrame(8'heb, 1, 24'($urandom), 4, 8'h00, 4, 4, 4, 2, 1'b1, -1);
		note("continuous");
		// wrapped quad reads run past the end of every section length
		cfg.wrapEnable <= 1'b1;
		for (t = 0; t < 4; t++)
		begin
			cfg.wrapLength <= 2'(t);
			readFrame(8'heb, 1, 24'($urandom), 4, 8'h00, 4, 4, 4, (8 << t) + 2, 1'b1, t);
		end
		note("wrap");
		// four-wire mode: dummies from parameter bits, start at a section end
		cfg.fourWireMode <= 1'b1;
		cfg.wrapLength <= 2'h0;
		readFrame(8'h0b, 4, 24'($urandom), 4, 8'h00, 0, 4, 4, 2, 1'b1, -1);
		for (t = 0; t < 4; t++)
		begin
			paramWrite <= 1'b1;
			paramBits <= 2'(t);
			@(posedge clk);
			paramWrite <= 1'b0;
			// both upper codes select eight dummies
			dq = (t == 3) ? 8 : 4 + 2 * t;
			a = 24'($urandom) | 24'h7;
			readFrame(8'h0b, 4, a, 4, 8'h00, 0, dq, 4, 2, 1'b1, -1);
			readFrame(8'heb, 4, a, 4, 8'h00, 4, dq - 2, 4, 2, 1'b1, -1);
			readFrame(8'h0c, 4, a, 4, 8'h00, 0, dq, 4, 2, 1'b1, 0);
		end
		resetCmd <= 1'b1;
		@(posedge clk);
		resetCmd <= 1'b0;
		readFrame(8'h0b, 4, 24'($urandom), 4, 8'h00, 0, 4, 4, 2, 1'b1, -1);
		note("four-wire");
		bufferTest();
		give_verdict();
	end
endmodule

`undef CHK
`default_nettype wire
